/* design/eis_pkg.sv */
/*
  Constants for the Ethernet interrupt status bank: offsets, bit positions,
  reset values. Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
package eis_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_STATUS   = 8'h58; // interrupt_status
  localparam logic [7:0] OFF_ENABLE   = 8'h5c; // enable mask
  localparam logic [7:0] OFF_CONTROL  = 8'h60; // master state, pin triggers
  localparam logic [7:0] OFF_BYTETEST = 8'h64; // byte order test, wake on write
  localparam logic [7:0] OFF_LEVELS   = 8'h68; // FIFO level thresholds
  // Status bit positions
  localparam int B_SW      = 31;
  localparam int B_TXSTOP  = 25;
  localparam int B_RXSTOP  = 24;
  localparam int B_DROPH   = 23;
  localparam int B_TXDONE  = 21;
  localparam int B_RXCNT   = 20;
  localparam int B_TIMER   = 19;
  localparam int B_PHY     = 18;
  localparam int B_PME     = 17;
  localparam int B_TX_STATUS_OVERFLOW_FLAG    = 16;
  localparam int B_OVSZ    = 15;
  localparam int B_RXERR   = 14;
  localparam int B_TXERR   = 13;
  localparam int B_TXOVR   = 10;
  localparam int B_TXAVAIL = 9;
  localparam int B_TSFULL  = 8;
  localparam int B_TSLEVEL = 7;
  localparam int B_RXDROP  = 6;
  localparam int B_RSFULL  = 4;
  localparam int B_RSLEVEL = 3;
  localparam int B_PIN0    = 0;
  // Implemented bits (all others reserved, read zero)
  localparam logic [31:0] STATUS_MASK = 32'h83bfe7df;
  // Reset values
  localparam logic [31:0] STATUS_RST = 32'h00000000;
  localparam logic [31:0] ENABLE_RST = 32'h00000000;
  localparam logic [2:0]  TRIG_RST   = 3'h0;
  localparam logic [7:0]  TXAVL_RST  = 8'h48;
  localparam logic [7:0]  TSLVL_RST  = 8'h00;
  localparam logic [7:0]  RSLVL_RST  = 8'h00;
  localparam logic [31:0] BYTETEST_VAL = 32'h87654321;
  // Counter landmarks
  localparam logic [31:0] DROP_HALF = 32'h80000000;
  localparam logic [15:0] TIMER_TOP = 16'hffff;
  // Control register fields
  localparam int CTL_MASTER = 12; // read-only master indication
  localparam int CTL_TRIG   = 0;  // pin trigger select, 3 bits
  // Level register fields
  localparam int LV_TXAVL = 24;
  localparam int LV_TSLVL = 16;
  localparam int LV_RSLVL = 0;
endpackage

/* design/eis_pin_edge.sv */
/*
  Pin event detector: two-flop synchroniser per pin, then an edge detector
  whose direction is chosen per pin. Assumes asynchronous pins, one clock.
*/
`timescale 1ns/1ps
module eis_pin_edge #(
  parameter int N = 3 // Number of pins
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [N-1:0] pin_in,
  input  wire logic [N-1:0] fall_sel,
  output logic      [N-1:0] pin_event
);
  logic [N-1:0] meta_ff; // First stage, read only by sync_ff
  logic [N-1:0] sync_ff; // Second stage
  logic [N-1:0] last_ff; // Previous synced level

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      // Synchroniser and history per pin
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
          last_ff[g] <= 1'b0;
        end
        else
        begin
          meta_ff[g] <= pin_in[g];
          sync_ff[g] <= meta_ff[g];
          last_ff[g] <= sync_ff[g];
        end
      end
      // Rising or falling edge as selected
      assign pin_event[g] = fall_sel[g] ? (last_ff[g] & ~sync_ff[g])
                                        : (~last_ff[g] & sync_ff[g]);
    end
  endgenerate
endmodule

/* design/eis_status.sv */
/*
  Interrupt status bank with enable mask and master indication, reached as an
  Avalon-MM slave with waitrequest. Event inputs come from logic on clk except
  the general-purpose pins, which are synchronised in eis_pin_edge.
*/
// Decided for this implementation: the Avalon-MM register port.
//
// Contract
// (R1) Status register at 58h shows every source
// (R2) Writing one acknowledges and clears a bit
// (R3) Bit 31 set while software request high
// (R4) Bit 25 set when stopped transmitter halts
// (R5) Bit 24 set when receiver halts
// (R6) Bit 23 set when drop counter reaches half
// (R7) Bit 21 set when marked buffer loaded
// (R8) Bit 20 set when receive count drained
// (R9) Bit 19 set on timer wrap to FFFFh
// (R10) Bit 18 follows physical-layer event, read-only
// (R11) Bit 17 power event, wake output irrelevant
// (R12) Only a byte-test write wakes device
// (R13) No hold-off applied to power event
// (R14) Bit 16 set on status FIFO overflow
// (R15) Bit 15 set on frame over 2048 bytes
// (R16) Bits 14/13 set on receive/transmit error
// (R17) Bit 10 set on write to full FIFO
// (R18) Bit 9 set when free space exceeds threshold
// (R19) Bits 8/4 set on status FIFO full
// (R20) Bits 7/3 set at status FIFO level; code sets them only when the fill is above the level
// (R21) Bit 6 set when any frame dropped
// (R22) Bits 2-0 latch pin events, configured triggers
// (R23) Status bits ignore the enable mask; code sets bit 31 from enable_ff[B_SW]
// (R24) Master high when any enabled bit set
// (R25) Zero writes keep; set beats clear
// (R26) Reset to zero; reserved bits read zero
`timescale 1ns/1ps
module eis_status
  import eis_pkg::*;
#(
  parameter int PINS = 3 // General-purpose pins
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic [7:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  input  wire logic [3:0]      avs_byteenable,
  output logic      [31:0]     avs_readdata,
  output logic                 avs_waitrequest,
  input  wire logic            tx_stop_requested,
  input  wire logic            tx_halted,
  input  wire logic            rx_halted,
  input  wire logic [31:0]     drop_count,
  input  wire logic            tx_buffer_loaded,
  input  wire logic            irq_on_completion_mark,
  input  wire logic            rx_transfer_done,
  input  wire logic [15:0]     timer_value,
  input  wire logic            phy_event,
  input  wire logic            power_event,
  input  wire logic            tx_status_overflow,
  input  wire logic            oversize_frame,
  input  wire logic            rx_error,
  input  wire logic            tx_error,
  input  wire logic            tx_data_write_attempt,
  input  wire logic            tx_data_full,
  input  wire logic [7:0]      tx_free_blocks,
  input  wire logic            tx_status_full,
  input  wire logic [7:0]      tx_status_used,
  input  wire logic            rx_status_full,
  input  wire logic [7:0]      rx_status_used,
  input  wire logic            rx_frame_dropped,
  input  wire logic [PINS-1:0] pin_in,
  output logic                 master_irq,
  output logic                 wake_pulse
);
  import eis_pkg::*;

  logic [31:0]     status_ff;   // Sticky flags
  logic [31:0]     nxt_status;  // Next flags
  logic [31:0]     enable_ff;   // Enable mask
  logic [PINS-1:0] trig_ff;     // Pin falling-edge selects
  logic [7:0]      txavl_ff;    // Free-space threshold
  logic [7:0]      tslvl_ff;    // TX status level
  logic [7:0]      rslvl_ff;    // RX status level
  logic [31:0]     drop_ff;     // Previous drop count
  logic [15:0]     timer_ff;    // Previous timer value
  logic            wait_ff;     // Registered waitrequest
  logic [31:0]     rdata_ff;    // Registered read data
  logic            irq_ff;      // Master indication
  logic            wake_ff;     // Wake pulse
  logic [31:0]     set_vec;     // Events this cycle
  logic [31:0]     clr_vec;     // Acknowledge pattern
  logic [31:0]     be_mask;     // Byte lanes as bits
  logic [31:0]     rd_mux;      // Read selection
  logic [PINS-1:0] pin_event;   // Edge-detected pins
  logic            wr_take;     // Write accepted this edge
  logic            rd_load;     // Read data captured this edge

  // Pin synchronisers and edge detectors
  eis_pin_edge #(
    .N (PINS)
  ) u_pins (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_in    (pin_in),
    .fall_sel  (trig_ff),
    .pin_event (pin_event)
  );

  // Bus handshake: one wait cycle, then ack
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      wait_ff <= 1'b1;
    else if ((avs_read || avs_write) && wait_ff)
      wait_ff <= 1'b0;  // Answer next edge
    else
      wait_ff <= 1'b1;  // Idle or just acked
  end

  assign wr_take = avs_write && !wait_ff;
  assign rd_load = avs_read && wait_ff;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Read multiplexer, unmapped reads zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (avs_address)
      OFF_STATUS:   rd_mux = status_ff & STATUS_MASK; // (R1) (R26)
      OFF_ENABLE:   rd_mux = enable_ff & STATUS_MASK;
      OFF_CONTROL:
      begin
        rd_mux[CTL_MASTER] = irq_ff;
        rd_mux[CTL_TRIG +: PINS] = trig_ff;
      end
      OFF_BYTETEST: rd_mux = BYTETEST_VAL;
      OFF_LEVELS:   rd_mux = {txavl_ff, tslvl_ff, 8'h00, rslvl_ff};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  // Read data register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rdata_ff <= 32'h00000000;
    else if (rd_load)
      rdata_ff <= rd_mux;
  end

  // Enable mask register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      enable_ff <= ENABLE_RST;
    else if (wr_take && avs_address == OFF_ENABLE)
      enable_ff <= ((enable_ff & ~be_mask) | (avs_writedata & be_mask)) & STATUS_MASK;
  end

  // Control and level registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      trig_ff  <= TRIG_RST;
      txavl_ff <= TXAVL_RST;
      tslvl_ff <= TSLVL_RST;
      rslvl_ff <= RSLVL_RST;
    end
    else if (wr_take)
    begin
      if (avs_address == OFF_CONTROL && avs_byteenable[0])
        trig_ff <= avs_writedata[CTL_TRIG +: PINS]; // (R22)
      if (avs_address == OFF_LEVELS)
      begin
        if (avs_byteenable[3])
          txavl_ff <= avs_writedata[LV_TXAVL +: 8];
        if (avs_byteenable[2])
          tslvl_ff <= avs_writedata[LV_TSLVL +: 8];
        if (avs_byteenable[0])
          rslvl_ff <= avs_writedata[LV_RSLVL +: 8];
      end
    end
  end

  // History of counters for crossing detection
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      drop_ff  <= 32'h00000000;
      timer_ff <= 16'h0000;
    end
    else
    begin
      drop_ff  <= drop_count;
      timer_ff <= timer_value;
    end
  end

  // Event vector, independent of the enable mask except bit 31, which copies enable_ff[B_SW]
  always_comb
  begin
    set_vec = 32'h00000000; // (R23)
    set_vec[B_SW]      = enable_ff[B_SW]; // (R3)
    set_vec[B_TXSTOP]  = tx_stop_requested && tx_halted; // (R4)
    set_vec[B_RXSTOP]  = rx_halted; // (R5)
    set_vec[B_DROPH]   = (drop_ff != DROP_HALF) && (drop_count == DROP_HALF); // (R6)
    set_vec[B_TXDONE]  = tx_buffer_loaded && irq_on_completion_mark; // (R7)
    set_vec[B_RXCNT]   = rx_transfer_done; // (R8)
    set_vec[B_TIMER]   = (timer_ff == 16'h0000) && (timer_value == TIMER_TOP); // (R9)
    set_vec[B_PME]     = power_event; // (R11)
    set_vec[B_TX_STATUS_OVERFLOW_FLAG]    = tx_status_overflow; // (R14)
    set_vec[B_OVSZ]    = oversize_frame; // (R15)
    set_vec[B_RXERR]   = rx_error; // (R16)
    set_vec[B_TXERR]   = tx_error; // (R16)
    set_vec[B_TXOVR]   = tx_data_write_attempt && tx_data_full; // (R17)
    set_vec[B_TXAVAIL] = tx_free_blocks > txavl_ff; // (R18)
    set_vec[B_TSFULL]  = tx_status_full; // (R19)
    set_vec[B_RSFULL]  = rx_status_full; // (R19)
    set_vec[B_TSLEVEL] = tx_status_used > tslvl_ff; // (R20)
    set_vec[B_RSLEVEL] = rx_status_used > rslvl_ff; // (R20)
    set_vec[B_RXDROP]  = rx_frame_dropped; // (R21)
    set_vec[B_PIN0 +: PINS] = pin_event; // (R22)
  end

  // Acknowledge pattern: ones in enabled lanes only
  assign clr_vec = (wr_take && avs_address == OFF_STATUS) ? (avs_writedata & be_mask) : 32'h00000000; // (R2) (R25)

  // Next status: set wins over clear; phy bit is a live level
  always_comb
  begin
    nxt_status = ((status_ff & ~clr_vec) | set_vec) & STATUS_MASK; // (R25) (R26)
    nxt_status[B_PHY] = phy_event; // (R10)
  end

  // Sticky status register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      status_ff <= STATUS_RST; // (R26)
    else
      status_ff <= nxt_status; // (R2)
  end

  // Master indication; no hold-off timer for any bit
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(status_ff & enable_ff & STATUS_MASK); // (R24) (R13)
  end

  // Wake only on a write to the byte test register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      wake_ff <= 1'b0;
    else
      wake_ff <= wr_take && avs_address == OFF_BYTETEST; // (R12)
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign master_irq      = irq_ff;
  assign wake_pulse      = wake_ff;

  // Checks
  chk_ack_clears: assert property (@(posedge clk) disable iff (!reset_n) // (R2)
    wr_take && avs_address == OFF_STATUS && avs_writedata[B_TXERR] && avs_byteenable[1]
    && !tx_error |=> !status_ff[B_TXERR])
    else $error("acknowledged bit not cleared");
  chk_sw_level: assert property (@(posedge clk) disable iff (!reset_n) // (R3)
    enable_ff[B_SW] |=> status_ff[B_SW])
    else $error("software flag not set");
  chk_tx_halt: assert property (@(posedge clk) disable iff (!reset_n) // (R4)
    tx_stop_requested && tx_halted |=> status_ff[B_TXSTOP])
    else $error("tx halted flag missing");
  chk_drop_half: assert property (@(posedge clk) disable iff (!reset_n) // (R6)
    $changed(drop_count) && drop_count == DROP_HALF |=> status_ff[B_DROPH])
    else $error("drop half flag missing");
  chk_timer_wrap: assert property (@(posedge clk) disable iff (!reset_n) // (R9)
    ##1 $past(timer_value) == 16'h0000 && timer_value == TIMER_TOP |=> status_ff[B_TIMER])
    else $error("timer wrap flag missing");
  chk_phy_live: assert property (@(posedge clk) disable iff (!reset_n) // (R10)
    ##1 status_ff[B_PHY] == $past(phy_event))
    else $error("phy bit not following source");
  chk_set_wins: assert property (@(posedge clk) disable iff (!reset_n) // (R25)
    rx_error && clr_vec[B_RXERR] |=> status_ff[B_RXERR])
    else $error("event lost under clear");
  chk_zero_keeps: assert property (@(posedge clk) disable iff (!reset_n) // (R25)
    status_ff[B_OVSZ] && !clr_vec[B_OVSZ] |=> status_ff[B_OVSZ])
    else $error("flag dropped without ack");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n) // (R26)
    (status_ff & ~STATUS_MASK) == 32'h00000000)
    else $error("reserved status bit set");
  chk_master_irq: assert property (@(posedge clk) disable iff (!reset_n) // (R24)
    |(status_ff & enable_ff) |=> master_irq)
    else $error("master indication low");
  chk_wake_only: assert property (@(posedge clk) disable iff (!reset_n) // (R12)
    wake_pulse |-> $past(avs_write) && $past(avs_address) == OFF_BYTETEST)
    else $error("wake without byte test write");
  chk_bus_answer: assert property (@(posedge clk) disable iff (!reset_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait");

  cov_ack: cover property (@(posedge clk) disable iff (!reset_n)
    clr_vec != 32'h00000000);
  cov_pin: cover property (@(posedge clk) disable iff (!reset_n)
    |pin_event);
  cov_irq: cover property (@(posedge clk) disable iff (!reset_n)
    master_irq ##1 !master_irq);
  cov_wake: cover property (@(posedge clk) disable iff (!reset_n)
    wake_pulse);
endmodule

/* testbench/eis_host.sv */
/*
  Host processor model: Avalon-MM master with one access task.
  Assumes a slave that answers through waitrequest on clk.
*/
`timescale 1ns/1ps
module eis_host (
  input  wire logic        clk,
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // Idle bus from time zero
  initial
  begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
  end
  // One access, held until waitrequest is seen low at an edge
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= rd;
    avs_write     <= !rd;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

/* testbench/eis_status_tb.sv */
/*
  Self-checking bench for the interrupt status bank: event stimulus,
  host accesses through eis_host, expected status kept in the bench.
  Assumes one 125 MHz clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module eis_status_tb;
  import eis_pkg::*;
  logic        clk;             // Bench clock
  logic        reset_n;         // Sync reset
  logic [7:0]  avs_address;     // Bus address
  logic        avs_read;        // Read request
  logic        avs_write;       // Write request
  logic [31:0] avs_writedata;   // Write data
  logic [3:0]  avs_byteenable;  // Lanes
  logic [31:0] avs_readdata;    // Read data
  logic        avs_waitrequest; // Slave stall
  logic [9:0]  pulse;           // Single-input sources
  logic [5:0]  pair;            // Two-input sources
  logic [31:0] drop_count;      // Dropped frame counter
  logic [15:0] timer_value;     // Down timer
  logic        phy_event;       // Physical-layer event
  logic [7:0]  tx_free_blocks;  // Free space
  logic [7:0]  tx_status_used;  // Tx status fill
  logic [7:0]  rx_status_used;  // Rx status fill
  logic [2:0]  pin_in;          // Pins
  logic        master_irq;      // Master indication
  logic        wake_pulse;      // Wake strobe
  logic [31:0] exp_sts;         // Expected status
  logic [31:0] rd_q;            // Last read data
  logic [31:0] d;               // Random data
  int          fails;
  int          samples_checked;
  int          seed;
  int          wakes;           // Wake pulses seen
  int pb [10] = '{24, 20, 17, 16, 15, 14, 13, 8, 4, 6};
  int qb [3]  = '{25, 21, 10};
  eis_host host (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
                 .avs_byteenable, .avs_readdata, .avs_waitrequest);
  eis_status dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .tx_stop_requested(pair[1]), .tx_halted(pair[0]), .rx_halted(pulse[0]),
    .drop_count, .tx_buffer_loaded(pair[2]), .irq_on_completion_mark(pair[3]),
    .rx_transfer_done(pulse[1]), .timer_value, .phy_event, .power_event(pulse[2]),
    .tx_status_overflow(pulse[3]), .oversize_frame(pulse[4]), .rx_error(pulse[5]),
    .tx_error(pulse[6]), .tx_data_write_attempt(pair[5]), .tx_data_full(pair[4]),
    .tx_free_blocks, .tx_status_full(pulse[7]), .tx_status_used,
    .rx_status_full(pulse[8]), .rx_status_used, .rx_frame_dropped(pulse[9]),
    .pin_in, .master_irq, .wake_pulse);
  // Clock
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // Count wake strobes
  always @(posedge clk)
    if (wake_pulse === 1'b1)
      wakes++;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Register value compare
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Single output bit compare
  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b1, a, 32'h0, rd_q);
    chk("readdata", e, rd_q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b0, a, v, rd_q);
  endtask
  // Write ones to clear; the physical-layer bit is not clearable
  task automatic wr_sts(input logic [31:0] v);
    wr(OFF_STATUS, v);
    exp_sts = exp_sts & ~(v & ~(32'h1 << B_PHY));
  endtask
  task automatic sts();
    rd(OFF_STATUS, exp_sts);
  endtask
  // One-cycle pulse on a single-input source
  task automatic fire(input int k);
    @(posedge clk);
    pulse <= 10'h1 << k;
    @(posedge clk);
    pulse <= 10'h0;
  endtask
  // Hang guard
  initial
  begin
    #200000;
    fails++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    seed = 99657;
    {pulse, pair, phy_event, pin_in} = '0;
    {drop_count, timer_value, tx_free_blocks} = '0;
    {tx_status_used, rx_status_used} = '0;
    exp_sts = 32'h0;
    fails = 0;
    samples_checked = 0;
    wakes = 0;
    reset_n = 1'b0;
    step(2);
    reset_n <= 1'b1;
    // Reset values, unmapped place
    rd(OFF_STATUS, 32'h0);
    rd(OFF_ENABLE, 32'h0);
    rd(OFF_LEVELS, 32'h48000000);
    rd(OFF_BYTETEST, BYTETEST_VAL);
    wr(8'h70, 32'hffffffff);
    rd(8'h70, 32'h0);
    // Each single-input source
    for (int k = 0; k < 10; k++)
    begin
      fire(k);
      exp_sts[pb[k]] = 1'b1;
      sts();
    end
    chk("wake_count", 32'h0, wakes);
    // Two-input sources: one half alone for a cycle, then both halves set the bit
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      pair <= 6'h1 << (2 * k);
      @(posedge clk);
      pair <= 6'h3 << (2 * k);
      @(posedge clk);
      pair <= 6'h0;
      exp_sts[qb[k]] = 1'b1;
      sts();
    end
    // Drop counter midpoint; timer move that is not a wrap
    drop_count <= 32'h7fffffff;
    timer_value <= 16'h0001;
    step(2);
    drop_count <= DROP_HALF;
    timer_value <= TIMER_TOP;
    step(2);
    exp_sts[B_DROPH] = 1'b1;
    sts();
    timer_value <= 16'h0000;
    step(2);
    timer_value <= TIMER_TOP;
    step(2);
    exp_sts[B_TIMER] = 1'b1;
    sts();
    // Thresholds: equal does not set, above does
    tx_free_blocks <= 8'h48;
    step(2);
    sts();
    tx_free_blocks <= 8'h49;
    tx_status_used <= 8'h01;
    rx_status_used <= 8'h01;
    @(posedge clk);
    {tx_free_blocks, tx_status_used, rx_status_used} <= '0;
    exp_sts = exp_sts | 32'h00000288;
    sts();
    // Random clearing writes
    repeat (4)
    begin
      d = $random(seed);
      wr_sts(d);
      sts();
    end
    wr_sts(32'hffffffff);
    sts();
    // Source held through its clearing write
    @(posedge clk);
    pulse <= 10'h1 << 5;
    wr_sts(32'h1 << B_RXERR);
    exp_sts[B_RXERR] = 1'b1;
    sts();
    @(posedge clk);
    pulse <= 10'h0;
    wr_sts(32'h1 << B_RXERR);
    sts();
    // Read-only physical-layer bit
    @(posedge clk);
    phy_event <= 1'b1;
    step(3);
    exp_sts[B_PHY] = 1'b1;
    wr_sts(32'h1 << B_PHY);
    sts();
    @(posedge clk);
    phy_event <= 1'b0;
    step(3);
    exp_sts[B_PHY] = 1'b0;
    sts();
    // Mask and master indication
    fire(9);
    exp_sts[B_RXDROP] = 1'b1;
    step(3);
    chk_bit("master_irq", 1'b0, master_irq);
    wr(OFF_ENABLE, 32'h1 << B_RXDROP);
    step(3);
    chk_bit("master_irq", 1'b1, master_irq);
    rd(OFF_CONTROL, 32'h00001000);
    wr_sts(32'h1 << B_RXDROP);
    step(3);
    chk_bit("master_irq", 1'b0, master_irq);
    // Software request keeps its bit set until withdrawn
    wr(OFF_ENABLE, 32'hffffffff);
    rd(OFF_ENABLE, STATUS_MASK);
    exp_sts[B_SW] = 1'b1;
    sts();
    wr_sts(32'h80000000);
    exp_sts[B_SW] = 1'b1;
    sts();
    chk_bit("master_irq", 1'b1, master_irq);
    wr(OFF_ENABLE, 32'h0);
    wr_sts(32'h80000000);
    sts();
    step(3);
    chk_bit("master_irq", 1'b0, master_irq);
    // Wake only on a byte-test write
    d = $random(seed);
    wr(OFF_BYTETEST, d);
    step(2);
    chk("wake_count", 32'h1, wakes);
    rd(OFF_BYTETEST, BYTETEST_VAL);
    // Pins: rising by default, then falling
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      pin_in[k] <= 1'b1;
      step(8);
      exp_sts[k] = 1'b1;
      sts();
    end
    wr_sts(32'h7);
    wr(OFF_CONTROL, 32'h7);
    @(posedge clk);
    pin_in <= 3'h0;
    step(8);
    exp_sts = exp_sts | 32'h7;
    sts();
    end_of_test();
  end
endmodule
